// ### core/biu_core.sv
`timescale 1ns/1ns
// How it works
// RULE_01: One NMI level above eight vectored levels
// RULE_02: NMI ignores mask and mode entirely
// RULE_03: Processor vectors NMI through fixed location
// RULE_04: Eight maskable levels get vectored identifiers
// RULE_05: Nested mode: line 0 highest, 7 lowest
// RULE_06: Rotating mode: serviced level becomes lowest
// RULE_07: Specific mode: software names lowest level
// RULE_08: Polled mode: status byte instead of interrupt
// RULE_09: Mode and priorities change live, no reset
// RULE_10: Interrupt only when winner outranks in-service
// RULE_11: Mask byte masks levels, one bit each
// RULE_12: Level vectors spaced four bytes apart
// RULE_13: Table is 32 bytes within low 1K
// RULE_14: Processor fetches identifier, then calls indirect
// RULE_15: Software avoids first 32 vector locations
// RULE_16: Twenty-six sources routed onto controller inputs
// RULE_17: Parallel port input-full and output-empty requests
// RULE_18: Each timer output selectable as source
// RULE_19: Eight system-bus request lines accepted
// RULE_20: Fail-safe, expansion, conversion, power, line clock
// RULE_21: Power fail qualified by mains-low warning
// RULE_22: Each level edge- or level-sensitive
// RULE_23: Processor multiplies identifier by four
// RULE_24: In-service holds until end of interrupt
module biu_core (
  input wire logic core_clk_in,                  // Processor clock
  input wire logic rst_in,                       // Async reset, high
  input wire logic ppi_in_full_in,               // Port input buffer full
  input wire logic ppi_out_empty_in,             // Port output emptied
  input wire logic [2:0] timer_out_in,           // Interval timer outputs
  input wire logic [7:0] sysbus_req_in,          // System bus requests
  input wire logic failsafe_in,                  // Fail-safe timer
  input wire logic [5:0] expansion_req_in,       // Expansion connectors
  input wire logic eoc_in,                       // End of conversion
  input wire logic power_fail_input_in,          // Power-fail pin
  input wire logic mains_low_warning_in,         // Supply mains-low
  input wire logic line_clock_in,                // Power line clock
  input wire logic [2:0] periph_req_in,          // Direct peripheral lines
  input wire logic [8*biu_pkg::SEL_W-1:0] route_sel_in, // Jumpers
  input wire biu_pkg::biu_mode_type mode_in,     // Priority mode
  input wire logic [7:0] mask_in,                // Mask byte
  input wire logic [2:0] lowest_in,              // Specific lowest level
  input wire logic [7:0] level_trig_in,          // 1 level, 0 edge
  input wire logic [biu_pkg::BASE_W-1:0] vector_base_in, // Table base
  input wire logic ack_in,                       // Acknowledge pulse
  input wire logic eoi_in,                       // End of interrupt pulse
  output logic nmi_out,                          // Non-maskable request
  output logic int_out,                          // Vectored request
  output logic [7:0] id_out,                     // Identifier byte
  output logic id_valid_out,                     // Identifier valid pulse
  output logic [7:0] poll_status_out,            // Polled status byte
  output logic [7:0] in_service_out              // In-service bits
);
  import biu_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam int RAW_W = SOURCES + 1;  // Sources plus mains-low
  logic [RAW_W-1:0] raw;               // Pins before sync
  logic [RAW_W-1:0] sync1;             // First sync stage
  logic [RAW_W-1:0] sync2;             // Second sync stage
  logic [SOURCES-1:0] src;             // Synced sources
  logic mains_low;                     // Synced mains-low
  logic [7:0] lvl_in;                  // Routed level inputs
  logic [7:0] lvl_prev;                // Previous routed inputs
  logic [7:0] irr;                     // Edge request latches
  logic [7:0] req;                     // Requests seen by resolver
  logic [7:0] req_eff;                 // Requests after mask
  logic [7:0] isr;                     // In-service bits
  logic [2:0] rot_low;                 // Rotating lowest level
  logic [2:0] low;                     // Active lowest level
  logic [2:0] win_lvl;                 // Highest pending level
  logic win_any;                       // Any pending level
  logic [RANK_W-1:0] win_rank;         // Rank of winner
  logic [2:0] top_isr;                 // Highest in-service level
  logic [RANK_W-1:0] isr_rank;         // Rank of top in-service
  logic outranks;                      // Winner beats in-service
  logic polled;                        // Polled mode selected
  logic take;                          // Acknowledge taken
  logic nmi_cond;                      // Qualified power fail
  logic [7:0] win_bit;                 // One-hot winner
  logic [7:0] top_bit;                 // One-hot top in-service
  logic [7:0] next_isr;                // Next in-service bits

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Gather all source pins and mains-low into one vector
  assign raw = {mains_low_warning_in, periph_req_in, line_clock_in,
                power_fail_input_in, eoc_in, expansion_req_in,
                failsafe_in, sysbus_req_in, timer_out_in,
                ppi_out_empty_in, ppi_in_full_in}; // RULE_16 RULE_17
                                                   // RULE_18 RULE_19
                                                   // RULE_20

  // Two flops before any logic reads a source or mains-low pin
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  assign src = sync2[SOURCES-1:0];
  assign mains_low = sync2[SOURCES];

  // ------------------------------------------------------------
  // Source routing and request latching, one slice per level
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LEVELS; g++) begin : g_lvl
      logic [SEL_W-1:0] sel;           // Source select for this level
      assign sel = route_sel_in[g*SEL_W +: SEL_W];
      // Select past the last source leaves the level idle
      assign lvl_in[g] = (int'(sel) < SOURCES) ? src[sel] : 1'b0; // RULE_16

      // Edge latch; a new edge wins over the acknowledge clear
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          irr[g] <= 1'b0;
        end else if (lvl_in[g] && !lvl_prev[g]) begin
          irr[g] <= 1'b1;                // RULE_22
        end else if (take && win_bit[g]) begin
          irr[g] <= 1'b0;
        end
      end

      // Level inputs follow the wire, edge inputs the latch
      assign req[g] = level_trig_in[g] ? lvl_in[g] : irr[g]; // RULE_22
      assign win_bit[g] = (win_lvl == 3'(g));
      assign top_bit[g] = (top_isr == 3'(g));
    end
  endgenerate

  // Remember last routed levels for edge detection
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lvl_prev <= RST_BYTE;
    end else begin
      lvl_prev <= lvl_in;
    end
  end

  // ------------------------------------------------------------
  // Priority resolution
  // ------------------------------------------------------------
  // Mask applies to maskable levels only
  assign req_eff = req & ~mask_in;   // RULE_11

  // Lowest level chosen live from the current mode
  assign low = (mode_in == BIU_ROTATE) ? rot_low :
               (mode_in == BIU_SPECIFIC) ? lowest_in :
               NESTED_LOWEST;        // RULE_05 RULE_07 RULE_09
  assign polled = (mode_in == BIU_POLLED); // RULE_08

  // Scan from the level just above the lowest one
  always_comb begin
    logic [2:0] lv;
    lv = 3'h0;
    win_lvl = 3'h0;
    win_any = 1'b0;
    win_rank = RANK_NONE;
    top_isr = 3'h0;
    isr_rank = RANK_NONE;
    for (int k = LEVELS - 1; k >= 0; k--) begin
      lv = low + 3'(k + 1);
      if (req_eff[lv]) begin          // RULE_04
        win_lvl = lv;
        win_any = 1'b1;
        win_rank = RANK_W'(k);
      end
      if (isr[lv]) begin
        top_isr = lv;
        isr_rank = RANK_W'(k);
      end
    end
  end

  // Only a strictly higher rank than in service may interrupt
  assign outranks = win_any && (win_rank < isr_rank); // RULE_10
  assign take = ack_in && outranks;
  assign nmi_cond = src[SRC_POWER_FAIL] && mains_low; // RULE_21

  // In-service set on acknowledge, cleared only by end of interrupt
  assign next_isr = (eoi_in ? (isr & ~top_bit) : isr) |
                    (take ? win_bit : RST_BYTE); // RULE_24

  // ------------------------------------------------------------
  // State and rotation
  // ------------------------------------------------------------
  // In-service bits and rotation pointer
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      isr <= RST_BYTE;
      rot_low <= RST_LOW;
    end else begin
      isr <= next_isr;               // RULE_24
      if (eoi_in && (isr != RST_BYTE)) begin
        rot_low <= top_isr;          // RULE_06
      end
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  // NMI bypasses mask and mode
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      nmi_out <= 1'b0;
    end else begin
      nmi_out <= nmi_cond;           // RULE_01 RULE_02 RULE_03
    end
  end

  // Interrupt line, identifier and status
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_out <= 1'b0;
      id_out <= RST_BYTE;
      id_valid_out <= 1'b0;
      poll_status_out <= RST_BYTE;
      in_service_out <= RST_BYTE;
    end else begin
      int_out <= outranks && !polled && !take; // RULE_08 RULE_10
      id_valid_out <= take;
      if (take) begin
        id_out <= {vector_base_in, win_lvl}; // RULE_12 RULE_13 RULE_23
      end
      poll_status_out <= {outranks, 4'h0, win_lvl}; // RULE_08
      in_service_out <= next_isr;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_nmi_unmasked: assert property (@(posedge core_clk_in) // RULE_02
    disable iff (rst_in) nmi_cond |=> nmi_out)
    else $error("NMI did not follow qualified power fail");

  a_nmi_needs_low: assert property (@(posedge core_clk_in) // RULE_21
    disable iff (rst_in) nmi_out |-> $past(mains_low))
    else $error("NMI raised without mains-low");

  a_mask_blocks: assert property (@(posedge core_clk_in) // RULE_11
    disable iff (rst_in) ($past(mask_in) == 8'hFF) |-> !int_out)
    else $error("Interrupt raised with all levels masked");

  a_poll_quiet: assert property (@(posedge core_clk_in) // RULE_08
    disable iff (rst_in) $past(polled) |-> !int_out)
    else $error("Interrupt raised in polled mode");

  a_nested_order: assert property (@(posedge core_clk_in) // RULE_05
    disable iff (rst_in)
    (mode_in == BIU_NESTED && req_eff[0]) |-> win_lvl == 3'h0)
    else $error("Line 0 not highest in nested mode");

  a_specific_top: assert property (@(posedge core_clk_in) // RULE_07
    disable iff (rst_in)
    (mode_in == BIU_SPECIFIC && req_eff[3'(lowest_in + 3'h1)])
    |-> win_lvl == 3'(lowest_in + 3'h1))
    else $error("Level above named lowest not highest");

  a_rotate_low: assert property (@(posedge core_clk_in) // RULE_06
    disable iff (rst_in)
    (eoi_in && isr != 8'h00) |=> rot_low == $past(top_isr))
    else $error("Serviced level did not become lowest");

  // Needs a pending unmasked level and a free top rank
  a_outrank_only: assert property (@(posedge core_clk_in) // RULE_10
    disable iff (rst_in)
    int_out |-> ($past(req_eff) != 8'h00) && ($past(isr_rank) != 4'h0))
    else $error("Interrupt without outranking request");

  a_isr_holds: assert property (@(posedge core_clk_in) // RULE_24
    disable iff (rst_in)
    !eoi_in |=> (isr & $past(isr)) == $past(isr))
    else $error("In-service bit dropped without end of interrupt");

  a_id_vector: assert property (@(posedge core_clk_in) // RULE_12
    disable iff (rst_in) take |=> id_valid_out &&
    id_out == {$past(vector_base_in), $past(win_lvl)})
    else $error("Identifier does not match base and level");

  c_nmi: cover property (@(posedge core_clk_in) disable iff (rst_in)
    nmi_out);
  c_ack: cover property (@(posedge core_clk_in) disable iff (rst_in)
    int_out ##[1:4] id_valid_out);
  c_nest: cover property (@(posedge core_clk_in) disable iff (rst_in)
    take && isr != 8'h00);
  c_poll: cover property (@(posedge core_clk_in) disable iff (rst_in)
    polled && poll_status_out[7]);
endmodule // biu_core

// ### dv/biu_cpu_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Processor model: acknowledges, fetches identifier, vectors
// ------------------------------------------------------------
module biu_cpu_model (
  input wire logic clk_in,              // Processor clock
  input wire logic rst_in,              // Async reset, high
  input wire logic int_in,              // Vectored request
  input wire logic nmi_in,              // Non-maskable request
  input wire logic id_valid_in,         // Identifier valid pulse
  input wire logic [7:0] id_in,         // Identifier byte
  input wire logic slow_in,             // Delay acknowledge
  output logic ack_out,                 // Acknowledge pulse
  output logic got_out,                 // Identifier fetched pulse
  output logic [7:0] id_seen_out,       // Last identifier
  output logic [9:0] vector_out,        // Derived vector address
  output logic [19:0] nmi_vector_out    // Fixed vector taken
);
  localparam logic [19:0] NMI_VECTOR = 20'h00008;
  logic [2:0] wait_cnt; // Delay and identifier wait count
  logic waiting; // Acknowledge issued
  // Acknowledge, then fetch identifier within a bounded wait
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      got_out <= 1'b0;
      waiting <= 1'b0;
      wait_cnt <= 3'h0;
      id_seen_out <= 8'h00;
      vector_out <= 10'h000;
      nmi_vector_out <= 20'h00000;
    end else begin
      ack_out <= 1'b0;
      got_out <= 1'b0;
      if (nmi_in) begin
        nmi_vector_out <= NMI_VECTOR;
      end
      if (waiting) begin
        wait_cnt <= wait_cnt + 3'h1;
        if (id_valid_in) begin
          // Identifier times four gives the vector
          waiting <= 1'b0;
          got_out <= 1'b1;
          id_seen_out <= id_in;
          vector_out <= {id_in, 2'b00};
        end else if (wait_cnt == 3'h3) begin
          waiting <= 1'b0; // Refused acknowledge, give up
        end
      end else if (int_in) begin
        if (!slow_in || wait_cnt == 3'h5) begin
          ack_out <= 1'b1;
          waiting <= 1'b1;
          wait_cnt <= 3'h0;
        end else begin
          wait_cnt <= wait_cnt + 3'h1;
        end
      end else begin
        wait_cnt <= 3'h0;
      end
    end
  end
endmodule // biu_cpu_model

// ### dv/board_interrupt_unit_tb.sv
`timescale 1ns/1ns
module board_interrupt_unit_tb;
  import biu_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observation
  // ------------------------------------------------------------
  logic clk, rst, mains_low, eoi, slow, ack, nmi, intr, idv, got;
  logic [25:0] src; // One bit per routed source index
  logic [39:0] route;
  biu_mode_type mode;
  logic [7:0] mask, trig, id, poll, insv, id_seen;
  logic [2:0] lowest;
  logic [4:0] base;
  logic [9:0] vec;
  logic [19:0] nvec;
  int fails, checks_done, cycles;
  biu_core biu_core_i (.core_clk_in(clk), .rst_in(rst),
    .ppi_in_full_in(src[0]), .ppi_out_empty_in(src[1]),
    .timer_out_in(src[4:2]), .sysbus_req_in(src[12:5]),
    .failsafe_in(src[13]), .expansion_req_in(src[19:14]),
    .eoc_in(src[20]), .power_fail_input_in(src[21]),
    .mains_low_warning_in(mains_low), .line_clock_in(src[22]),
    .periph_req_in(src[25:23]), .route_sel_in(route), .mode_in(mode),
    .mask_in(mask), .lowest_in(lowest), .level_trig_in(trig),
    .vector_base_in(base), .ack_in(ack), .eoi_in(eoi), .nmi_out(nmi),
    .int_out(intr), .id_out(id), .id_valid_out(idv),
    .poll_status_out(poll), .in_service_out(insv));
  biu_cpu_model biu_cpu_model_i (.clk_in(clk), .rst_in(rst),
    .int_in(intr), .nmi_in(nmi), .id_valid_in(idv), .id_in(id),
    .slow_in(slow), .ack_out(ack), .got_out(got), .id_seen_out(id_seen),
    .vector_out(vec), .nmi_vector_out(nvec));
  // ------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait for the processor to fetch an identifier, check it
  task automatic expect_id(input logic [2:0] lvl);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 40 && !hit; i++) begin
      // Read at the edge: sees what the previous edge launched
      @(posedge clk);
      hit = got;
    end
    check(hit, 1'b1);
    check(id_seen, {base, lvl});
    check(vec, {base, lvl, 2'b00});
  endtask
  // Request line must not interrupt for n cycles
  task automatic quiet(input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge clk);
      if (intr !== 1'b0) ok = 1'b0;
    end
    check(ok, 1'b1);
  endtask
  task automatic end_int();
    @(posedge clk);
    eoi <= 1'b1;
    @(posedge clk);
    eoi <= 1'b0;
    // Let the cleared bit reach the outputs
    @(posedge clk);
  endtask
  // Drop a source, let it settle, then end the interrupt
  task automatic release_src(input int idx);
    @(posedge clk);
    src[idx] <= 1'b0;
    repeat (4) @(posedge clk);
    end_int();
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    src = '0;
    mains_low = 1'b0;
    eoi = 1'b0;
    slow = 1'b0;
    mode = BIU_NESTED;
    mask = 8'h00;
    trig = 8'hFF;
    lowest = 3'h7;
    // Table above the reserved first 32 vectors
    base = 5'h04;
    fails = 0;
    checks_done = 0;
    cycles = 0;
    for (int g = 0; g < 8; g++) route[5*g +: 5] = 5'(SRC_SYSBUS + g);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Nested order, outranking and in-service hold
    @(posedge clk);
    src[8] <= 1'b1;
    src[10] <= 1'b1;
    expect_id(3'h3);
    src[8] <= 1'b0;
    check(insv, 8'h08);
    quiet(8);
    src[6] <= 1'b1;
    expect_id(3'h1);
    check(insv, 8'h0A);
    release_src(6);
    check(insv, 8'h08);
    end_int();
    expect_id(3'h5);
    release_src(10);
    check(insv, 8'h00);
    // Mask byte
    mask <= 8'h04;
    src[7] <= 1'b1;
    quiet(8);
    mask <= 8'h00;
    expect_id(3'h2);
    release_src(7);
    // Rotating mode with a slow processor
    mode <= BIU_ROTATE;
    slow <= 1'b1;
    src[5] <= 1'b1;
    expect_id(3'h0);
    release_src(5);
    src[5] <= 1'b1;
    src[6] <= 1'b1;
    expect_id(3'h1);
    release_src(6);
    expect_id(3'h0);
    release_src(5);
    slow <= 1'b0;
    // Specific mode, level 3 named lowest
    mode <= BIU_SPECIFIC;
    lowest <= 3'h3;
    src[7] <= 1'b1;
    src[10] <= 1'b1;
    expect_id(3'h5);
    release_src(10);
    expect_id(3'h2);
    release_src(7);
    // Edge-sensitive level 4, one-cycle pulse
    mode <= BIU_NESTED;
    trig <= 8'hEF;
    src[9] <= 1'b1;
    @(posedge clk);
    src[9] <= 1'b0;
    expect_id(3'h4);
    end_int();
    trig <= 8'hFF;
    // Polled mode
    mode <= BIU_POLLED;
    src[11] <= 1'b1;
    quiet(8);
    check(poll, 8'h86);
    src[11] <= 1'b0;
    repeat (5) @(posedge clk);
    check(poll[7], 1'b0);
    // Power fail qualified by mains low, unaffected by mask
    mask <= 8'hFF;
    src[21] <= 1'b1;
    repeat (6) @(posedge clk);
    check(nmi, 1'b0);
    mains_low <= 1'b1;
    repeat (5) @(posedge clk);
    check(nmi, 1'b1);
    check(nvec, 20'h00008);
    src[21] <= 1'b0;
    mains_low <= 1'b0;
    mask <= 8'h00;
    mode <= BIU_NESTED;
    repeat (4) @(posedge clk);
    // Every source routed onto level 0
    for (int s = 0; s < SOURCES; s++) begin
      @(posedge clk);
      route[4:0] <= 5'(s);
      @(posedge clk);
      src[s] <= 1'b1;
      expect_id(3'h0);
      release_src(s);
    end
    route[4:0] <= 5'h1A;
    src[0] <= 1'b1;
    quiet(8);
    src[0] <= 1'b0;
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule // board_interrupt_unit_tb

// ### shared/biu_pkg.sv
package biu_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int LEVELS = 8;           // Maskable controller levels
  localparam int SOURCES = 26;         // Selectable request sources
  localparam int SEL_W = 5;            // Width of one source select
  localparam int BASE_W = 5;           // Vector base, 32-byte units
  localparam int RANK_W = 4;           // Rank, 8 means no level
  localparam logic [RANK_W-1:0] RANK_NONE = 4'h8;
  localparam logic [2:0] NESTED_LOWEST = 3'h7;  // Fixed order, 7 lowest
  // ------------------------------------------------------------
  // Source index map inside the routed source vector
  // ------------------------------------------------------------
  localparam int SRC_PPI_IN_FULL = 0;
  localparam int SRC_PPI_OUT_EMPTY = 1;
  localparam int SRC_TIMER = 2;        // Three timer outputs, 2..4
  localparam int SRC_SYSBUS = 5;       // Eight bus lines, 5..12
  localparam int SRC_FAILSAFE = 13;
  localparam int SRC_EXPANSION = 14;   // Six module lines, 14..19
  localparam int SRC_EOC = 20;
  localparam int SRC_POWER_FAIL = 21;
  localparam int SRC_LINE_CLOCK = 22;
  localparam int SRC_PERIPH = 23;      // Three direct lines, 23..25
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_LOW = 3'h7;
  // ------------------------------------------------------------
  // Priority modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BIU_NESTED = 2'h0,
    BIU_ROTATE = 2'h1,
    BIU_SPECIFIC = 2'h3,
    BIU_POLLED = 2'h2
  } biu_mode_type;
endpackage
